// [hdl/flash_id_map.vh]
`ifndef FLASH_ID_MAP_VH
`define FLASH_ID_MAP_VH
// command opcodes
`define OP_RELEASE_SIG 8'hab
`define OP_MAKER_PART 8'h90
`define OP_DUAL_MAKER_PART 8'h92
`define OP_IDENT 8'h9f
`define OP_RESET_ARM 8'h66
`define OP_RESET 8'h99
`define OP_UNIQUE 8'h4b
// address byte selecting output order
`define ADDR_MAKER_FIRST 8'h00
`define ADDR_PART_FIRST 8'h01
// dummy / preamble bytes after the opcode
`define SIG_DUMMY_BYTES 3
`define MP_PRE_BYTES 3
`define DUAL_PRE_BYTES 4
`define UNIQUE_DUMMY_BYTES 4
// delays and clock period in ns
`define RELEASE_DELAY_NS 3000
`define SIG_EXIT_DELAY_NS 1800
`define CLK_PERIOD_NS 10
// bit widths
`define IDENT_BITS 24
`define UNIQUE_BITS 128
`endif

// [hdl/pin_sync.v]
// three-stage synchroniser; change accepted once stages two and three agree
module pin_sync #(
  parameter RESET_VAL = 1'b0
) (
  input wire clk_i,
  input wire rst_i,
  input wire d_i,
  output reg q_o
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  // shift chain and agreement filter
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_reg <= RESET_VAL;
      s2_reg <= RESET_VAL;
      s3_reg <= RESET_VAL;
      q_o <= RESET_VAL;
    end else begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        q_o <= s3_reg;
      end
    end
  end
endmodule // pin_sync

// [hdl/delay_timer.v]
// one-shot down counter; busy_o high while the delay runs
module delay_timer #(
  parameter WIDTH = 12
) (
  input wire clk_i,
  input wire rst_i,
  input wire start_i,
  input wire [WIDTH-1:0] count_i,
  output wire busy_o
);
  reg [WIDTH-1:0] cnt_reg;

  // load on start, count down to zero
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= {WIDTH{1'b0}};
    end else if (start_i) begin
      cnt_reg <= count_i;
    end else if (cnt_reg != {WIDTH{1'b0}}) begin
      cnt_reg <= cnt_reg - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  assign busy_o = (cnt_reg != {WIDTH{1'b0}});
endmodule // delay_timer

// [hdl/flash_id_powerdown_reset_cmds.v]
// Functional notes
// - in deep power-down only the release/signature opcode is acted on
// - release-only from power-down: after select rises, commands refused for release delay
// - signature read: opcode, three dummy bytes, then device id msb first
// - device id repeats while select stays low
// - signature read outside power-down returns to standby at once
// - from power-down, standby follows the signature exit delay
// - release/signature returns the 8-bit device id unless a busy cycle or a running delay refuses it
// - release/signature ignored while erase/program/status-write runs
// - 90h: two dummy bytes, address byte, then maker and part ids
// - address 00h gives maker id first, 01h gives part id first
// - maker and part ids alternate while select stays low
// - 92h: dual-line preamble with mode byte, ids out on two lines
// - 9fh: 24 bits out, maker, memory type, capacity
// - identification read ignored while erase or program runs
// - select rising ends identification read, device back to standby
// - 99h right after 66h resets volatile state to power-on defaults
// - any other command after 66h disarms the reset
// - software reset aborts a running program or erase
// - 4bh: four dummy bytes, then the 128-bit unique number
// - opcode and address bits sampled on rising serial clock
`include "flash_id_map.vh"
module flash_id_powerdown_reset_cmds #(
  parameter [7:0] MAKER_ID = 8'h5a, // arbitrary value
  parameter [7:0] PART_ID = 8'h12, // arbitrary value
  parameter [7:0] MEM_TYPE = 8'h60, // arbitrary value
  parameter [7:0] CAPACITY = 8'h12, // arbitrary value
  // factory number: arbitrary value
  parameter [127:0] UNIQUE_NUM = 128'h0123456789abcdeffedcba9876543210,
  parameter RELEASE_DELAY_NS = `RELEASE_DELAY_NS,
  parameter SIG_EXIT_DELAY_NS = `SIG_EXIT_DELAY_NS
) (
  input wire clk_i,
  input wire rst_i,
  input wire select_n_i,
  input wire sclk_i,
  input wire data_line_0_i,
  output reg data_line_0_o,
  output reg data_line_0_oe_o,
  input wire data_line_1_i,
  output reg data_line_1_o,
  output reg data_line_1_oe_o,
  input wire cycle_busy_i,
  input wire status_write_busy_i,
  input wire powerdown_enter_i,
  output reg powerdown_o,
  output wire standby_o,
  output reg soft_reset_o
);
  // clock period comes from the map header; a new clock needs it changed
  // cycles derived from delays: longest-time style values round up here
  // because the device must not accept commands early
  localparam REL_CYC = (RELEASE_DELAY_NS + `CLK_PERIOD_NS - 1)
    / `CLK_PERIOD_NS;
  localparam EXIT_CYC = (SIG_EXIT_DELAY_NS + `CLK_PERIOD_NS - 1)
    / `CLK_PERIOD_NS;

  // states; ST_IGNORE swallows the rest of a refused or finished command
  // and drives nothing until select rises
  localparam [2:0] ST_OPCODE = 3'd0;
  localparam [2:0] ST_PRE = 3'd1;
  localparam [2:0] ST_OUT = 3'd2;
  localparam [2:0] ST_IGNORE = 3'd3;
  // output kinds
  localparam [2:0] K_SIG = 3'd0;
  localparam [2:0] K_MP = 3'd1;
  localparam [2:0] K_DUAL = 3'd2;
  localparam [2:0] K_IDENT = 3'd3;
  localparam [2:0] K_UNIQUE = 3'd4;

  wire sel_n;
  wire sclk;
  wire d0;
  wire d1;
  wire timer_busy;

  // every pin crosses into the clock domain through three flops and a filtered output flop;
  // select resets high and clock low, their idle levels;
  // the sampled serial clock must stay below one eighth of clk_i
  pin_sync #(.RESET_VAL(1'b1)) u_sel (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(select_n_i),
    .q_o(sel_n)
  );
  pin_sync #(.RESET_VAL(1'b0)) u_sclk (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(sclk_i),
    .q_o(sclk)
  );
  pin_sync #(.RESET_VAL(1'b0)) u_d0 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(data_line_0_i),
    .q_o(d0)
  );
  pin_sync #(.RESET_VAL(1'b0)) u_d1 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(data_line_1_i),
    .q_o(d1)
  );

  // decoder state; counters restart whenever select is high
  // swap_reg holds the pair order, armed_reg the reset enable
  // was_pd_reg remembers power-down at the release opcode
  reg sclk_d_reg;
  reg sel_n_d_reg;
  reg [2:0] state_reg;
  reg [2:0] kind_reg;
  reg [7:0] shift_reg;
  reg [2:0] bit_cnt_reg;
  reg [2:0] byte_cnt_reg;
  reg [7:0] addr_reg;
  reg [6:0] out_idx_reg;
  reg swap_reg;
  reg armed_reg;
  reg armed_hit_reg;
  reg release_seen_reg;
  reg was_pd_reg;
  reg timer_start_reg;
  reg [11:0] timer_count_reg;

  // edges of the synchronised pins, one clk_i cycle wide; data pins
  // pass the same chain, so they line up with their clock edge
  wire sclk_rise = sclk & ~sclk_d_reg;
  wire sclk_fall = ~sclk & sclk_d_reg;
  wire sel_rise = sel_n & ~sel_n_d_reg;
  wire dual_in = (state_reg == ST_PRE) && (kind_reg == K_DUAL);
  wire [7:0] byte_in = dual_in ? {shift_reg[5:0], d1, d0}
    : {shift_reg[6:0], d0};
  wire [2:0] step = dual_in ? 3'd2 : 3'd1;
  wire byte_done = dual_in ? (bit_cnt_reg == 3'd6)
    : (bit_cnt_reg == 3'd7);
  wire [7:0] ident_byte = (out_idx_reg[6:3] == 4'd0) ? MAKER_ID
    : (out_idx_reg[6:3] == 4'd1) ? MEM_TYPE : CAPACITY;
  // a pending timer load also holds standby off, otherwise standby
  // would flash high for one cycle between release and timer start
  assign standby_o = sel_n & ~timer_busy & ~timer_start_reg & ~powerdown_o;

  // id byte of an alternating pair; odd byte index flips the choice
  function [7:0] pair_byte;
    input sw;
    input odd;
    begin
      pair_byte = (sw ^ odd) ? PART_ID : MAKER_ID;
    end
  endfunction

  // current bytes of the alternating pair, single and dual line
  wire [7:0] mp_byte = pair_byte(swap_reg, out_idx_reg[3]);
  wire [7:0] dual_byte = pair_byte(swap_reg, out_idx_reg[2]);

  // release and exit delays; opcodes are refused while it runs
  delay_timer #(.WIDTH(12)) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(timer_start_reg),
    .count_i(timer_count_reg),
    .busy_o(timer_busy)
  );

  // edge history; reset values match the idle pin levels
  // so no false edge follows reset
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_d_reg <= 1'b0;
      sel_n_d_reg <= 1'b1;
    end else begin
      sclk_d_reg <= sclk;
      sel_n_d_reg <= sel_n;
    end
  end

  // command decode, preamble count and output shifting
  // the opcode byte decides the state; refused opcodes park in the
  // ignore state until select rises
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_OPCODE;
      kind_reg <= K_SIG;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 3'd0;
      byte_cnt_reg <= 3'd0;
      addr_reg <= 8'h00;
      out_idx_reg <= 7'd0;
      swap_reg <= 1'b0;
      armed_reg <= 1'b0;
      armed_hit_reg <= 1'b0;
      release_seen_reg <= 1'b0;
      was_pd_reg <= 1'b0;
      powerdown_o <= 1'b0;
      soft_reset_o <= 1'b0;
      timer_start_reg <= 1'b0;
      timer_count_reg <= 12'd0;
      data_line_0_o <= 1'b0;
      data_line_0_oe_o <= 1'b0;
      data_line_1_o <= 1'b0;
      data_line_1_oe_o <= 1'b0;
    end else begin
      timer_start_reg <= 1'b0;
      soft_reset_o <= 1'b0;
      if (sel_n) begin
        // deselected: end any command, go toward standby
        state_reg <= ST_OPCODE;
        bit_cnt_reg <= 3'd0;
        byte_cnt_reg <= 3'd0;
        out_idx_reg <= 7'd0;
        data_line_0_oe_o <= 1'b0;
        data_line_1_oe_o <= 1'b0;
        // a release from power-down starts the delay that refuses
        // opcodes; outside power-down standby follows at once
        if (sel_rise && release_seen_reg) begin
          release_seen_reg <= 1'b0;
          if (was_pd_reg) begin
            timer_start_reg <= 1'b1;
            timer_count_reg <= (kind_reg == K_SIG && state_reg == ST_OUT)
              ? EXIT_CYC[11:0] : REL_CYC[11:0];
            powerdown_o <= 1'b0;
          end // otherwise standby at once
        end
        // reset acts on select rise; a program or erase outside is
        // aborted, volatile state returns to its power-on values
        if (sel_rise && armed_hit_reg) begin
          armed_hit_reg <= 1'b0;
          soft_reset_o <= 1'b1;
          armed_reg <= 1'b0;
          powerdown_o <= 1'b0;
          swap_reg <= 1'b0;
        end
      end else if (sclk_rise && state_reg != ST_OUT
                   && state_reg != ST_IGNORE) begin
        // input bits taken on rising serial clock
        shift_reg <= byte_in;
        bit_cnt_reg <= bit_cnt_reg + step;
        if (byte_done) begin
          bit_cnt_reg <= 3'd0;
          if (state_reg == ST_OPCODE) begin
            // every opcode decides the reset enable afresh
            armed_reg <= (byte_in == `OP_RESET_ARM);
            state_reg <= ST_IGNORE;
            byte_cnt_reg <= 3'd0;
            // refusals first: running delay, then power-down
            if (timer_busy) begin
              state_reg <= ST_IGNORE;
            end else if (powerdown_o && byte_in != `OP_RELEASE_SIG) begin
              state_reg <= ST_IGNORE;
            end else if (byte_in == `OP_RELEASE_SIG) begin
              if (!(cycle_busy_i || status_write_busy_i)) begin
                kind_reg <= K_SIG;
                state_reg <= ST_PRE;
                release_seen_reg <= 1'b1;
                was_pd_reg <= powerdown_o;
              end
            end else if (byte_in == `OP_MAKER_PART) begin
              kind_reg <= K_MP;
              state_reg <= ST_PRE;
            end else if (byte_in == `OP_DUAL_MAKER_PART) begin
              kind_reg <= K_DUAL;
              state_reg <= ST_PRE;
            end else if (byte_in == `OP_IDENT) begin
              if (!cycle_busy_i) begin
                kind_reg <= K_IDENT;
                state_reg <= ST_OUT;
              end
            end else if (byte_in == `OP_UNIQUE) begin
              kind_reg <= K_UNIQUE;
              state_reg <= ST_PRE;
            end else if (byte_in == `OP_RESET && armed_reg) begin
              armed_hit_reg <= 1'b1;
            end
          end else begin
            byte_cnt_reg <= byte_cnt_reg + 3'd1;
            if (byte_cnt_reg == 3'd2) begin
              addr_reg <= byte_in;
            end
            // last preamble byte: switch to output, latch pair order
            if ((kind_reg == K_SIG
                 && byte_cnt_reg == `SIG_DUMMY_BYTES - 1)
                || (kind_reg == K_MP
                 && byte_cnt_reg == `MP_PRE_BYTES - 1)
                || (kind_reg == K_DUAL
                 && byte_cnt_reg == `DUAL_PRE_BYTES - 1)
                || (kind_reg == K_UNIQUE
                 && byte_cnt_reg == `UNIQUE_DUMMY_BYTES - 1)) begin
              state_reg <= ST_OUT;
              out_idx_reg <= 7'd0;
              if (kind_reg == K_MP) begin
                swap_reg <= (byte_in == `ADDR_PART_FIRST);
              end else if (kind_reg == K_DUAL) begin
                swap_reg <= (addr_reg == `ADDR_PART_FIRST);
              end
            end
          end
        end
      end else if (sclk_fall && state_reg == ST_OUT) begin
        // output bits change on falling serial clock, msb first
        // line 1 enable, and line 0 enable for dual only, rise with the first bit and hold until select rises
        out_idx_reg <= out_idx_reg + 7'd1;
        data_line_0_oe_o <= (kind_reg == K_DUAL);
        data_line_1_oe_o <= 1'b1;
        case (kind_reg)
          K_SIG: begin
            // signature: the part id repeats every eight bits
            data_line_1_o <= PART_ID[3'd7 - out_idx_reg[2:0]];
          end
          K_MP: begin
            data_line_1_o <= mp_byte[3'd7 - out_idx_reg[2:0]];
          end
          K_DUAL: begin
            // line 1 carries the high bit of each pair
            data_line_1_o <=
              dual_byte[3'd7 - {out_idx_reg[1:0], 1'b0}];
            data_line_0_o <=
              dual_byte[3'd6 - {out_idx_reg[1:0], 1'b0}];
          end
          K_IDENT: begin
            if (out_idx_reg < `IDENT_BITS) begin
              data_line_1_o <= ident_byte[3'd7 - out_idx_reg[2:0]];
            end else begin
              // after 24 bits the line idles low until select rises
              out_idx_reg <= out_idx_reg;
              data_line_1_o <= 1'b0;
            end
          end
          default: begin
            // 128-bit number, msb first like the other ids
            data_line_1_o <= UNIQUE_NUM[7'd127 - out_idx_reg];
          end
        endcase
      end
      // entry placed last so it wins over a release in the same cycle
      if (powerdown_enter_i) begin
        powerdown_o <= 1'b1;
      end
    end
  end
endmodule // flash_id_powerdown_reset_cmds

// [dv/flash_id_monitor.sv]
module flash_id_monitor #(
  parameter RELEASE_DELAY_NS = 3000
) (
  input wire clk_i,
  input wire rst_i,
  input wire select_n_i,
  input wire sclk_i,
  input wire data_line_0_i,
  input wire data_line_0_o,
  input wire data_line_0_oe_o,
  input wire data_line_1_i,
  input wire data_line_1_o,
  input wire data_line_1_oe_o,
  input wire cycle_busy_i,
  input wire status_write_busy_i,
  input wire powerdown_enter_i,
  input wire powerdown_o,
  input wire standby_o,
  input wire soft_reset_o
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WAKE_MAX = RELEASE_DELAY_NS / 10 + 700;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // standby held off eight cycles after a release, then back within the delay plus 700 cycles
  sequence wake_hold_s;
    (!standby_o) [*8];
  endsequence
  pd_wake_a: assert property (
    $fell(powerdown_o) |-> wake_hold_s ##[1:WAKE_MAX] standby_o)
    else $error("standby timing after release wrong");
  pd_no_dual_a: assert property (
    powerdown_o |-> !data_line_0_oe_o)
    else $error("dual output while powered down");
  pd_no_idle_a: assert property (
    powerdown_o |-> !standby_o)
    else $error("standby while powered down");
  sel_busy_a: assert property (
    !select_n_i [*8] |-> !standby_o)
    else $error("standby while selected");
  desel_quiet_a: assert property (
    select_n_i [*8] |-> !data_line_0_oe_o && !data_line_1_oe_o)
    else $error("output driven while deselected");
  reset_pulse_a: assert property (
    soft_reset_o |-> select_n_i ##1 !soft_reset_o)
    else $error("soft reset pulse malformed");
  out_fall_a: assert property (
    data_line_1_oe_o && $past(data_line_1_oe_o) && $changed(data_line_1_o)
      |-> !sclk_i)
    else $error("output changed while serial clock high");
  dual_both_a: assert property (
    data_line_0_oe_o |-> data_line_1_oe_o)
    else $error("line 0 driven without line 1");
endmodule // flash_id_monitor

// [dv/flash_host_model.sv]
module flash_host_model (
  output logic select_n_o,
  output logic sclk_o,
  output logic line0_o,
  output logic line1_o,
  output logic line1_oe_o,
  input wire line0_i,
  input wire line1_i
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle: deselected, clock parked low
  initial begin
    select_n_o = 1'b1;
    sclk_o = 1'b0;
    line0_o = 1'b0;
    line1_o = 1'b0;
    line1_oe_o = 1'b0;
  end
  // opens or closes a frame; line 0 flips level and line 1 is released
  task frame(input logic on);
    #62.5;
    select_n_o = !on;
    line0_o = !line0_o;
    line1_oe_o = 1'b0;
    #62.5;
  endtask
  // one byte msb first, dual puts the high bit on line 1
  task xfer(input logic dual, drv, input logic [7:0] tx,
            output logic [7:0] rx);
    for (int i = 7; i >= 0; i -= 1 + dual) begin
      line0_o = tx[i - dual];
      line1_o = tx[i];
      line1_oe_o = drv;
      #62.5;
      sclk_o = 1'b1;
      #60;
      rx[i] = line1_i;
      if (dual) rx[i - 1] = line0_i;
      #2.5;
      sclk_o = 1'b0;
    end
  endtask
endmodule // flash_host_model

// [dv/flash_id_powerdown_reset_cmds_tb.sv]
module flash_id_powerdown_reset_cmds_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam [7:0] MAKER = 8'h3c; // arbitrary value
  localparam [7:0] PART = 8'h21; // arbitrary value
  localparam [7:0] MEM = 8'h44; // arbitrary value
  localparam [7:0] CAP = 8'h13; // arbitrary value
  // arbitrary value standing in for the factory number
  localparam [127:0] UNQ = 128'h00112233445566778899aabbccddeeff;
  logic clk_i = 0, rst_i = 1, busy = 0, sw_busy = 0, pd_enter = 0;
  wire h_sel_n, h_sclk, h0, h1, h1_oe, d0, d0_oe, d1, d1_oe, pd, stby, srst;
  wire w0 = d0_oe ? d0 : h0;
  wire w1 = d1_oe ? d1 : (h1_oe ? h1 : ~d1);
  int num_errors = 0, n_checks = 0, n_rst = 0;
  logic [7:0] rx;
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (srst === 1'b1) n_rst <= n_rst + 1;
  flash_id_powerdown_reset_cmds #(.MAKER_ID(MAKER), .PART_ID(PART),
    .MEM_TYPE(MEM), .CAPACITY(CAP), .UNIQUE_NUM(UNQ),
    .RELEASE_DELAY_NS(1000), .SIG_EXIT_DELAY_NS(500)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .select_n_i(h_sel_n), .sclk_i(h_sclk),
    .data_line_0_i(w0), .data_line_0_o(d0), .data_line_0_oe_o(d0_oe),
    .data_line_1_i(w1), .data_line_1_o(d1), .data_line_1_oe_o(d1_oe),
    .cycle_busy_i(busy), .status_write_busy_i(sw_busy),
    .powerdown_enter_i(pd_enter), .powerdown_o(pd), .standby_o(stby),
    .soft_reset_o(srst));
  flash_host_model u_host (.select_n_o(h_sel_n), .sclk_o(h_sclk),
    .line0_o(h0), .line1_o(h1), .line1_oe_o(h1_oe), .line0_i(w0),
    .line1_i(w1));
  task results;
    if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task check(input logic [7:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task chk1(input logic seen, exp);
    check({7'h0, seen}, {7'h0, exp});
  endtask
  task wait_clk(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task send(input logic [7:0] b);
    u_host.xfer(1'b0, 1'b0, b, rx);
  endtask
  task rd(input logic [7:0] exp);
    u_host.xfer(1'b0, 1'b0, 8'h00, rx);
    check(rx, exp);
  endtask
  task open(input logic [7:0] op, input int ndum);
    u_host.frame(1'b1);
    send(op);
    repeat (ndum) send(8'h00);
  endtask
  task close;
    u_host.frame(1'b0);
    wait_clk(10);
  endtask
  task op1(input logic [7:0] op);
    open(op, 0);
    close;
  endtask
  task pd_on;
    pd_enter <= 1'b1;
    wait_clk(1);
    pd_enter <= 1'b0;
    wait_clk(5);
  endtask
  // identification read, then select rise ends it
  task t_ident;
    open(8'h9f, 0);
    rd(MAKER);
    rd(MEM);
    rd(CAP);
    close;
    chk1(d1_oe, 1'b0);
    chk1(stby, 1'b1);
  endtask
  // maker/part read in both orders, repeating
  task t_maker;
    for (int a = 0; a < 2; a++) begin
      open(8'h90, 2);
      send(a[7:0]);
      repeat (2) begin
        rd(a ? PART : MAKER);
        rd(a ? MAKER : PART);
      end
      close;
    end
  endtask
  // signature read repeats the part byte
  task t_sig;
    open(8'hab, 3);
    repeat (3) rd(PART);
    close;
    chk1(stby, 1'b1);
  endtask
  // unique number, most significant byte first
  task t_unique;
    open(8'h4b, 4);
    for (int i = 15; i >= 0; i--) rd(UNQ[i*8 +: 8]);
    close;
  endtask
  // dual read, address 01h, part first
  task t_dual;
    open(8'h92, 0);
    u_host.xfer(1'b1, 1'b1, 8'h00, rx);
    u_host.xfer(1'b1, 1'b1, 8'h00, rx);
    u_host.xfer(1'b1, 1'b1, 8'h01, rx);
    u_host.xfer(1'b1, 1'b1, 8'h20, rx);
    for (int i = 0; i < 3; i++) begin
      u_host.xfer(1'b1, 1'b0, 8'h00, rx);
      check(rx, i[0] ? MAKER : PART);
    end
    close;
  endtask
  // power-down refusal, release and exit delays
  task t_pd;
    pd_on;
    chk1(pd, 1'b1);
    open(8'h90, 3); // no maker/part read while powered down
    send(8'h00);
    chk1(d1_oe, 1'b0);
    close;
    op1(8'hab);
    chk1(pd, 1'b0);
    chk1(stby, 1'b0);
    wait_clk(110);
    chk1(stby, 1'b1);
    pd_on;
    open(8'hab, 3);
    rd(PART);
    close;
    chk1(stby, 1'b0);
    wait_clk(60);
    chk1(stby, 1'b1);
  endtask
  // busy cycles refuse signature and identification reads
  task t_busy;
    for (int k = 0; k < 3; k++) begin
      busy <= (k != 2);
      sw_busy <= (k == 2);
      open(k == 1 ? 8'h9f : 8'hab, k == 1 ? 0 : 3);
      send(8'h00);
      chk1(d1_oe, 1'b0);
      close;
    end
    busy <= 1'b0;
    sw_busy <= 1'b0;
  endtask
  // reset only straight after arming, also while busy
  task t_reset;
    int base;
    base = n_rst;
    op1(8'h66);
    op1(8'h99);
    check(8'(n_rst - base), 8'h01);
    chk1(stby, 1'b1);
    op1(8'h66);
    op1(8'h9f);
    op1(8'h99);
    check(8'(n_rst - base), 8'h01);
    busy <= 1'b1;
    op1(8'h66);
    op1(8'h99);
    busy <= 1'b0;
    check(8'(n_rst - base), 8'h02);
  endtask
  initial begin
    wait_clk(5);
    rst_i <= 1'b0;
    wait_clk(10);
    t_ident;
    t_maker;
    t_sig;
    t_unique;
    t_dual;
    t_pd;
    t_busy;
    t_reset;
    results;
  end
  initial begin
    #900us;
    num_errors++;
    results;
  end
endmodule // flash_id_powerdown_reset_cmds_tb

bind flash_id_powerdown_reset_cmds flash_id_monitor #(
  .RELEASE_DELAY_NS(RELEASE_DELAY_NS)) u_mon (
  .clk_i(clk_i), .rst_i(rst_i), .select_n_i(select_n_i), .sclk_i(sclk_i),
  .data_line_0_i(data_line_0_i), .data_line_0_o(data_line_0_o),
  .data_line_0_oe_o(data_line_0_oe_o), .data_line_1_i(data_line_1_i),
  .data_line_1_o(data_line_1_o), .data_line_1_oe_o(data_line_1_oe_o),
  .cycle_busy_i(cycle_busy_i), .status_write_busy_i(status_write_busy_i),
  .powerdown_enter_i(powerdown_enter_i), .powerdown_o(powerdown_o),
  .standby_o(standby_o), .soft_reset_o(soft_reset_o));
